/* verilog/sbf_top.sv */
// Serial unit flags, transmit buffer, double receive buffer and registers
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module sbf_top
  import sbf_pkg::*;
(
  input  wire logic       SYS_CLK,
  input  wire logic       NRST,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic [7:0]      RDATA,
  output logic            IRQ,
  input  wire logic       SCK_IN,
  output logic            SCK_OUT,
  output logic            SCK_OE,
  input  wire logic       SDI,
  output logic            SDO,
  output logic            SDO_OE,
  input  wire logic       SS_N_IN
);
  sbf_pins_t  pins_raw;
  sbf_pins_t  pins_s;
  logic       enable_reg;
  logic       master_reg;
  logic       buffered_mode_enable_reg;
  logic       ssd_reg;
  logic [7:0] intctrl_reg;
  logic [7:0] txbuf_reg;
  logic       txfull_reg;
  logic       dre_reg;
  logic       txc_reg;
  logic       write_collision_flag_reg;
  logic       wc_arm_reg;
  logic       if_reg;
  logic       if_arm_reg;
  logic       select_trigger_flag_reg;
  logic       ovf_reg;
  logic       ovf_pend_reg;
  logic [7:0] rx1_reg;
  logic [7:0] rx2_reg;
  logic       rx1v_reg;
  logic       rx2v_reg;
  logic [7:0] rx1_next;
  logic [7:0] rx2_next;
  logic       rx1v_next;
  logic       rx2v_next;
  logic       ovf_hit;
  logic [7:0] flag_view;
  logic [7:0] rdata_next;
  logic       dat_wr;
  logic       dat_rd;
  logic       flg_wr;
  logic       flg_rd;
  logic       busy;
  logic       start;
  logic       done;
  logic [7:0] rx_byte;
  logic       ss_act;
  logic       ss_fault;
  logic       load_direct;
  logic       load_buf;
  logic       sck_drv;
  logic       sdo_drv;

  assign pins_raw = '{sck: SCK_IN, sdi: SDI, ss_n: SS_N_IN};
  assign dat_wr = WR && ADDR == ADR_DATA;
  assign dat_rd = RD && ADDR == ADR_DATA;
  assign flg_wr = WR && ADDR == ADR_FLAGS;
  assign flg_rd = RD && ADDR == ADR_FLAGS;
  assign ss_act = enable_reg && !master_reg && !pins_s.ss_n;
  assign ss_fault = enable_reg && master_reg && !ssd_reg && !pins_s.ss_n;
  assign load_direct = enable_reg && !buffered_mode_enable_reg && dat_wr && !busy;
  assign load_buf = enable_reg && buffered_mode_enable_reg && txfull_reg && !busy;

  sbf_sync u_sync (
    .clk   (SYS_CLK),
    .rst_n (NRST),
    .d     (pins_raw),
    .q     (pins_s)
  );

  sbf_shifter u_shift (
    .clk       (SYS_CLK),
    .rst_n     (NRST),
    .master    (master_reg),
    .go        (load_direct || load_buf),
    .din       (buffered_mode_enable_reg ? txbuf_reg : WDATA),
    .ss_act    (ss_act),
    .sck_s     (pins_s.sck),
    .sdi_s     (pins_s.sdi),
    .sck_reg   (sck_drv),
    .sdo_reg   (sdo_drv),
    .busy      (busy),
    .start_reg (start),
    .done_reg  (done),
    .sh_reg    (rx_byte)
  );

  // Control registers; a select fault overrides a master write
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      enable_reg <= 1'b0;
      master_reg <= 1'b0;
      buffered_mode_enable_reg <= 1'b0;
      ssd_reg <= 1'b0;
      intctrl_reg <= BYTE_RST;
    end else begin
      if (WR && ADDR == ADR_CTRLA) begin
        enable_reg <= WDATA[CA_ENABLE];
        master_reg <= WDATA[CA_MASTER];
      end
      if (ss_fault) master_reg <= 1'b0;
      if (WR && ADDR == ADR_CTRLB) begin
        buffered_mode_enable_reg <= WDATA[CB_BUFFERED_MODE_ENABLE];
        ssd_reg <= WDATA[CB_SSD];
      end
      if (WR && ADDR == ADR_INTCTRL) intctrl_reg <= WDATA;
    end
  end

  // Transmit buffer; a write in the load cycle refills it
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      txbuf_reg <= BYTE_RST;
      txfull_reg <= 1'b0;
      dre_reg <= 1'b0;
    end else if (dat_wr && buffered_mode_enable_reg) begin
      txbuf_reg <= WDATA;
      txfull_reg <= 1'b1;
      dre_reg <= 1'b0;
    end else if (load_buf) begin
      txfull_reg <= 1'b0;
      dre_reg <= 1'b1;
    end
  end

  // Collision and legacy flags, cleared by flag read then data access
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      write_collision_flag_reg <= 1'b0;
      wc_arm_reg <= 1'b0;
      if_reg <= 1'b0;
      if_arm_reg <= 1'b0;
    end else begin
      if (flg_rd && write_collision_flag_reg) wc_arm_reg <= 1'b1;
      else if (dat_wr || dat_rd) wc_arm_reg <= 1'b0;
      if (dat_wr && busy) write_collision_flag_reg <= 1'b1;
      else if (wc_arm_reg && (dat_wr || dat_rd)) write_collision_flag_reg <= 1'b0;
      if (flg_rd && if_reg) if_arm_reg <= 1'b1;
      else if (dat_wr || dat_rd) if_arm_reg <= 1'b0;
      if ((done || ss_fault) && !buffered_mode_enable_reg) if_reg <= 1'b1;
      else if ((flg_wr && WDATA[FL_RXC]) || (if_arm_reg && (dat_wr || dat_rd))) if_reg <= 1'b0;
    end
  end

  // Buffered completion and select flags; set beats write-one clear
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      txc_reg <= 1'b0;
      select_trigger_flag_reg <= 1'b0;
    end else begin
      if (buffered_mode_enable_reg && done && !txfull_reg) txc_reg <= 1'b1;
      else if (flg_wr && WDATA[FL_TXC]) txc_reg <= 1'b0;
      if (buffered_mode_enable_reg && ss_fault) select_trigger_flag_reg <= 1'b1;
      else if (flg_wr && WDATA[FL_SS]) select_trigger_flag_reg <= 1'b0;
    end
  end

  // Receive stages: pop first, then place the new byte
  always_comb begin
    rx1_next = rx1_reg;
    rx2_next = rx2_reg;
    rx1v_next = rx1v_reg;
    rx2v_next = rx2v_reg;
    ovf_hit = 1'b0;
    if (dat_rd && buffered_mode_enable_reg) begin
      rx2_next = rx1_reg;
      rx2v_next = rx1v_reg;
      rx1v_next = 1'b0;
    end
    if (done && !buffered_mode_enable_reg) begin
      rx2_next = rx_byte;
    end else if (done) begin
      if (!rx2v_next) begin
        rx2_next = rx_byte;
        rx2v_next = 1'b1;
      end else if (!rx1v_next) begin
        rx1_next = rx_byte;
        rx1v_next = 1'b1;
      end else begin
        ovf_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rx1_reg <= BYTE_RST;
      rx2_reg <= BYTE_RST;
      rx1v_reg <= 1'b0;
      rx2v_reg <= 1'b0;
    end else begin
      rx1_reg <= rx1_next;
      rx2_reg <= rx2_next;
      rx1v_reg <= rx1v_next;
      rx2v_reg <= rx2v_next;
    end
  end

  // Overflow waits for the next start when nothing is queued to send
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ovf_reg <= 1'b0;
      ovf_pend_reg <= 1'b0;
    end else begin
      if (ovf_hit && !txfull_reg) ovf_pend_reg <= 1'b1;
      else if (start) ovf_pend_reg <= 1'b0;
      if ((ovf_hit && txfull_reg) || (ovf_pend_reg && start)) ovf_reg <= 1'b1;
      else if (dat_rd) ovf_reg <= 1'b0;
    end
  end

  // Bit zero of a flag write is ignored
  always_comb begin
    flag_view = BYTE_RST;
    flag_view[FL_RXC] = buffered_mode_enable_reg ? rx2v_reg : if_reg;
    flag_view[FL_TXC] = buffered_mode_enable_reg ? txc_reg : write_collision_flag_reg;
    flag_view[FL_DRE] = buffered_mode_enable_reg && dre_reg;
    flag_view[FL_SS] = buffered_mode_enable_reg && select_trigger_flag_reg;
    flag_view[FL_OVF] = buffered_mode_enable_reg && ovf_reg;
    case (ADDR)
      ADR_CTRLA: begin
        rdata_next = BYTE_RST;
        rdata_next[CA_ENABLE] = enable_reg;
        rdata_next[CA_MASTER] = master_reg;
      end
      ADR_CTRLB: begin
        rdata_next = BYTE_RST;
        rdata_next[CB_BUFFERED_MODE_ENABLE] = buffered_mode_enable_reg;
        rdata_next[CB_SSD] = ssd_reg;
      end
      ADR_INTCTRL: rdata_next = intctrl_reg;
      ADR_FLAGS: rdata_next = flag_view;
      ADR_DATA: rdata_next = rx2_reg;
      default: rdata_next = BYTE_RST;
    endcase
  end

  // Level interrupt stays while any enabled flag except overflow stands; unbuffered, only the legacy flag counts
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= BYTE_RST;
      IRQ <= 1'b0;
      SCK_OE <= 1'b0;
      SDO_OE <= 1'b0;
    end else begin
      if (RD) RDATA <= rdata_next;
      IRQ <= buffered_mode_enable_reg ? |(flag_view[FL_RXC:FL_SS] & intctrl_reg[FL_RXC:FL_SS])
                       : (if_reg && intctrl_reg[IE_LEGACY]);
      SCK_OE <= enable_reg && master_reg;
      SDO_OE <= enable_reg && (master_reg || ss_act);
    end
  end

  assign SCK_OUT = sck_drv;
  assign SDO = sdo_drv;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  a_txc_on_empty: assert property (buffered_mode_enable_reg && done && !txfull_reg |=> txc_reg)
    else $error("transfer complete not set");
  a_write_collision_flag_busy_write: assert property (dat_wr && busy |=> write_collision_flag_reg)
    else $error("write collision not set");
  a_write_collision_flag_clear_seq: assert property (wc_arm_reg && dat_rd && !busy ##0 !(dat_wr) |=> !write_collision_flag_reg)
    else $error("write collision not cleared");
  a_dre_unbuf_zero: assert property (flg_rd && !buffered_mode_enable_reg |=> !RDATA[FL_DRE])
    else $error("buffer empty flag seen unbuffered");
  a_dre_write_clear: assert property (dat_wr && buffered_mode_enable_reg |=> !dre_reg && txfull_reg)
    else $error("data write left buffer empty flag");
  a_irq_dre_level: assert property (buffered_mode_enable_reg && dre_reg && intctrl_reg[FL_DRE] |=> IRQ)
    else $error("buffer empty interrupt dropped");
  a_ss_fault_drop: assert property (ss_fault && buffered_mode_enable_reg |=> !master_reg && select_trigger_flag_reg)
    else $error("select fault not handled");
  a_ssd_keeps_master: assert property (master_reg && ssd_reg && !(WR && ADDR == ADR_CTRLA) |=> master_reg)
    else $error("master lost with select disabled");
  a_ovf_unbuf_zero: assert property (flg_rd && !buffered_mode_enable_reg |=> !RDATA[FL_OVF])
    else $error("overflow seen unbuffered");
  a_ovf_read_clear: assert property (dat_rd && !ovf_hit && !(ovf_pend_reg && start) |=> !ovf_reg)
    else $error("overflow survived data read");
  a_tx_start: assert property (load_direct && master_reg |=> busy ##[1:40] done)
    else $error("transmission did not run");
  a_rx_first_free: assert property (done && buffered_mode_enable_reg && !rx2v_reg |=> rx2v_reg && rx2_reg == $past(rx_byte))
    else $error("received byte misplaced");
  a_buf_load: assert property (load_buf && !dat_wr |=> dre_reg && !txfull_reg)
    else $error("pending byte not loaded");
endmodule : sbf_top

/* verilog/sbf_pkg.sv */
// Shared constants and types for the buffered serial flags and data path
package sbf_pkg;
  localparam logic [2:0] ADR_CTRLA   = 3'h0;
  localparam logic [2:0] ADR_CTRLB   = 3'h1;
  localparam logic [2:0] ADR_INTCTRL = 3'h2;
  localparam logic [2:0] ADR_FLAGS   = 3'h3;
  localparam logic [2:0] ADR_DATA    = 3'h4;
  localparam int CA_ENABLE = 0;
  localparam int CA_MASTER = 5;
  localparam int CB_SSD    = 2;
  localparam int CB_BUFFERED_MODE_ENABLE  = 7;
  localparam int FL_OVF    = 0;
  localparam int FL_SS     = 4;
  localparam int FL_DRE    = 5;
  localparam int FL_TXC    = 6;
  localparam int FL_RXC    = 7;
  localparam int IE_LEGACY = 0;
  localparam logic [7:0] BYTE_RST   = 8'h00;
  localparam logic [3:0] BITS_LAST  = 4'h7;
  localparam logic [3:0] BITS_DONE  = 4'h8;
  // Serial clock is the system clock divided by four
  localparam int SCK_DIV = 4;
  localparam logic [1:0] SCK_HALF_LAST = 2'(SCK_DIV / 2 - 1);
  typedef struct packed {
    logic sck;
    logic sdi;
    logic ss_n;
  } sbf_pins_t;
endpackage : sbf_pkg

/* verilog/sbf_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module sbf_sync
  import sbf_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire sbf_pins_t d,
  output sbf_pins_t      q
);
  sbf_pins_t meta_reg;

  // Idle pin levels: clock low, select high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '{sck: 1'b0, sdi: 1'b0, ss_n: 1'b1};
      q        <= '{sck: 1'b0, sdi: 1'b0, ss_n: 1'b1};
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : sbf_sync

/* verilog/sbf_shifter.sv */
// Byte shift engine, master and slave, line sampled at leading edge, MSB first
`timescale 1ns/1ps
module sbf_shifter
  import sbf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       master,
  input  wire logic       go,
  input  wire logic [7:0] din,
  input  wire logic       ss_act,
  input  wire logic       sck_s,
  input  wire logic       sdi_s,
  output logic            sck_reg,
  output logic            sdo_reg,
  output logic            busy,
  output logic            start_reg,
  output logic            done_reg,
  output logic [7:0]      sh_reg
);
  logic [3:0] cnt_reg;
  logic [1:0] div_reg;
  logic       busy_reg;
  logic       sck_q_reg;
  logic       act_q_reg;
  logic       tick;

  assign tick = div_reg == SCK_HALF_LAST;
  assign busy = master ? busy_reg : (cnt_reg != 4'h0);

  // Divider enable pulse paces the master clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) div_reg <= 2'h0;
    else if (!busy_reg || tick) div_reg <= 2'h0;
    else div_reg <= div_reg + 2'h1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_reg <= BYTE_RST;
      cnt_reg <= 4'h0;
      busy_reg <= 1'b0;
      sck_reg <= 1'b0;
      sdo_reg <= 1'b0;
      sck_q_reg <= 1'b0;
      act_q_reg <= 1'b0;
      start_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      start_reg <= 1'b0;
      sck_q_reg <= sck_s;
      act_q_reg <= ss_act;
      if (go && !busy) begin
        sh_reg <= din;
        sdo_reg <= din[7];
        cnt_reg <= 4'h0;
        start_reg <= master;
        busy_reg <= master;
        sck_reg <= 1'b0;
      end else if (master && busy_reg && tick) begin
        if (!sck_reg) begin
          sck_reg <= 1'b1;
          cnt_reg <= cnt_reg + 4'h1;
        end else begin
          // Shift at the fall: sync delay makes this the line level at the rise
          sck_reg <= 1'b0;
          sh_reg <= {sh_reg[6:0], sdi_s};
          if (cnt_reg == BITS_DONE) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
          end else begin
            sdo_reg <= sh_reg[6];
          end
        end
      end else if (!master) begin
        // Losing master mid-byte abandons that byte
        busy_reg <= 1'b0;
        sck_reg <= 1'b0;
        if (ss_act && !act_q_reg) start_reg <= 1'b1;
        if (!ss_act) begin
          cnt_reg <= 4'h0;
        end else if (sck_s && !sck_q_reg) begin
          sh_reg <= {sh_reg[6:0], sdi_s};
          if (cnt_reg == BITS_LAST) begin
            cnt_reg <= 4'h0;
            done_reg <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end else if (!sck_s && sck_q_reg) begin
          sdo_reg <= sh_reg[7];
        end
      end
    end
  end
endmodule : sbf_shifter

/* verification/sbf_partner.sv */
// Behavioural far-side serial device: slave to our master, master inside frames
`timescale 1ns/1ps
module sbf_partner (
  input  wire logic sck_out,
  input  wire logic sck_oe,
  input  wire logic sdo,
  output logic      sck_in,
  output logic      sdi,
  output logic      ss_n
);
  logic [7:0] sh_reg  = 8'h00;
  logic [7:0] nxt_reg = 8'h00;
  logic [7:0] got     = 8'h00;
  logic [3:0] cnt     = 4'h0;
  logic       lead    = 1'b0;
  logic       sck;
  initial begin
    sck_in = 1'b0;
    ss_n   = 1'b1;
  end
  // Released data line shows the inverse, never a stale copy
  assign sdi = (sck_oe || !ss_n) ? sh_reg[7] : !sh_reg[7];
  assign sck = lead ? sck_in : sck_out;
  always @(posedge sck) got <= {got[6:0], sdo};
  // Each byte answered differs, so arrival order shows in the reads
  always @(negedge sck) begin
    if (cnt == 4'h7) begin
      cnt     <= 4'h0;
      sh_reg  <= nxt_reg + 8'h11;
      nxt_reg <= nxt_reg + 8'h11;
    end else begin
      cnt    <= cnt + 4'h1;
      sh_reg <= {sh_reg[6:0], sh_reg[7]};
    end
  end
  task automatic load(input logic [7:0] b);
    sh_reg  = b;
    nxt_reg = b;
    cnt     = 4'h0;
  endtask : load
  task automatic select(input logic lvl);
    ss_n <= lvl;
  endtask : select
  // Clock only runs inside the frame, 160 ns period
  task automatic frame(input logic [7:0] b);
    load(b);
    lead = 1'b1;
    ss_n <= 1'b0;
    #320;
    repeat (8) begin
      #80 sck_in <= 1'b1;
      #80 sck_in <= 1'b0;
    end
    #320;
    ss_n <= 1'b1;
    lead = 1'b0;
  endtask : frame
endmodule : sbf_partner

/* verification/test_spi_buffered_flags_and_data_path.sv */
// Self-checking bench for the buffered serial flags and data path
`timescale 1ns/1ps
module test_spi_buffered_flags_and_data_path
  import sbf_pkg::*;
;
  logic       SYS_CLK;
  logic       NRST;
  logic [2:0] ADDR;
  logic [7:0] WDATA;
  logic       WR;
  logic       RD;
  logic [7:0] RDATA;
  logic       IRQ;
  logic       SCK_IN;
  logic       SCK_OUT;
  logic       SCK_OE;
  logic       SDI;
  logic       SDO;
  logic       SDO_OE;
  logic       SS_N_IN;
  int         failures   = 0;
  int         num_checks = 0;
  logic [7:0] v;
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  sbf_top DUT (
    .SYS_CLK (SYS_CLK), .NRST (NRST), .ADDR (ADDR), .WDATA (WDATA), .WR (WR), .RD (RD),
    .RDATA (RDATA), .IRQ (IRQ), .SCK_IN (SCK_IN), .SCK_OUT (SCK_OUT), .SCK_OE (SCK_OE),
    .SDI (SDI), .SDO (SDO), .SDO_OE (SDO_OE), .SS_N_IN (SS_N_IN)
  );
  sbf_partner partner (
    .sck_out (SCK_OUT), .sck_oe (SCK_OE), .sdo (SDO), .sck_in (SCK_IN), .sdi (SDI), .ss_n (SS_N_IN)
  );
  task automatic close_out();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Gap cycle between strobes keeps each strobe one clock wide
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge SYS_CLK);
    WR    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge SYS_CLK);
    RD   <= 1'b0;
    #1 d = RDATA;
  endtask : rd
  task automatic wait_flag(input logic [7:0] m);
    for (int i = 0; i < 100; i++) begin
      rd(ADR_FLAGS, v);
      if ((v & m) === m) return;
    end
    failures++;
    $display("[FAIL] flag wait expected %h seen %h", m, v);
    close_out();
  endtask : wait_flag
  task automatic t_reset();
    rd(ADR_FLAGS, v);
    chk("flags at reset", 8'h00, v);
    rd(ADR_DATA, v);
    chk("data at reset", BYTE_RST, v);
    wr(3'h5, 8'hFF);
    rd(3'h5, v);
    chk("unmapped", 8'h00, v);
    chk("irq idle", 8'h00, {7'h00, IRQ});
    chk("drivers idle", 8'h00, {6'h00, SCK_OE, SDO_OE});
  endtask : t_reset
  task automatic t_unbuf();
    partner.load(8'hA5);
    wr(ADR_CTRLA, 8'h21);
    wr(ADR_INTCTRL, 8'h01);
    chk("drivers on", 8'h03, {6'h00, SCK_OE, SDO_OE});
    wr(ADR_DATA, 8'h3C);
    wr(ADR_DATA, 8'h77);
    rd(ADR_FLAGS, v);
    chk("collision", 8'h40, v & 8'h61);
    wait_flag(8'h80);
    chk("irq unbuffered", 8'h01, {7'h00, IRQ});
    chk("sent byte", 8'h3C, partner.got);
    rd(ADR_DATA, v);
    chk("received", 8'hA5, v);
    rd(ADR_FLAGS, v);
    chk("collision cleared", 8'h00, v & 8'hC0);
  endtask : t_unbuf
  task automatic t_buf_tx();
    partner.load(8'h50);
    wr(ADR_CTRLB, 8'h80);
    wr(ADR_INTCTRL, 8'h20);
    rd(ADR_FLAGS, v);
    chk("empty flag idle", 8'h00, v & 8'h20);
    wr(ADR_DATA, 8'h11);
    wr(ADR_DATA, 8'h22);
    rd(ADR_FLAGS, v);
    chk("buffer held", 8'h00, v & 8'h60);
    chk("irq quiet", 8'h00, {7'h00, IRQ});
    wait_flag(8'h20);
    chk("irq empty", 8'h01, {7'h00, IRQ});
    wait_flag(8'h40);
    chk("second sent", 8'h22, partner.got);
    chk("irq level", 8'h01, {7'h00, IRQ});
    wr(ADR_INTCTRL, 8'h00);
    wr(ADR_FLAGS, 8'h40);
    rd(ADR_FLAGS, v);
    chk("complete cleared", 8'h80, v & 8'hC0);
    chk("irq masked", 8'h00, {7'h00, IRQ});
  endtask : t_buf_tx
  task automatic t_overflow();
    wr(ADR_DATA, 8'h33);
    wait_flag(8'h40);
    chk("overflow deferred", 8'h00, v & 8'h01);
    wr(ADR_FLAGS, 8'h40);
    wr(ADR_DATA, 8'h44);
    wait_flag(8'h40);
    chk("overflow", 8'h01, v & 8'h01);
    rd(ADR_DATA, v);
    chk("oldest first", 8'h50, v);
    rd(ADR_FLAGS, v);
    chk("overflow cleared", 8'h00, v & 8'h01);
    rd(ADR_DATA, v);
    chk("next byte", 8'h61, v);
    rd(ADR_FLAGS, v);
    chk("rx empty", 8'h00, v & 8'h80);
  endtask : t_overflow
  task automatic t_select();
    wr(ADR_CTRLA, 8'h21);
    wr(ADR_CTRLB, 8'h84);
    wr(ADR_INTCTRL, 8'h10);
    partner.select(1'b0);
    repeat (8) @(posedge SYS_CLK);
    rd(ADR_CTRLA, v);
    chk("master kept", 8'h21, v);
    rd(ADR_FLAGS, v);
    chk("no trigger", 8'h00, v & 8'h10);
    partner.select(1'b1);
    wr(ADR_CTRLB, 8'h80);
    repeat (8) @(posedge SYS_CLK);
    partner.select(1'b0);
    repeat (8) @(posedge SYS_CLK);
    rd(ADR_CTRLA, v);
    chk("master dropped", 8'h01, v);
    chk("slave drive", 8'h01, {6'h00, SCK_OE, SDO_OE});
    rd(ADR_FLAGS, v);
    chk("trigger", 8'h10, v & 8'h10);
    chk("irq trigger", 8'h01, {7'h00, IRQ});
    partner.select(1'b1);
    wr(ADR_FLAGS, 8'h10);
    rd(ADR_FLAGS, v);
    chk("trigger cleared", 8'h00, v & 8'h10);
  endtask : t_select
  task automatic t_slave();
    wr(ADR_CTRLA, 8'h01);
    wr(ADR_DATA, 8'h96);
    partner.frame(8'hC3);
    rd(ADR_DATA, v);
    chk("slave received", 8'hC3, v);
    chk("slave sent", 8'h96, partner.got);
  endtask : t_slave
  initial begin
    NRST  <= 1'b0;
    ADDR  <= 3'h0;
    WDATA <= 8'h00;
    WR    <= 1'b0;
    RD    <= 1'b0;
    repeat (20) @(posedge SYS_CLK);
    NRST <= 1'b1;
    t_reset();
    t_unbuf();
    t_buf_tx();
    t_overflow();
    t_select();
    t_slave();
    close_out();
  end
endmodule : test_spi_buffered_flags_and_data_path
